// >>> hw/pms_top.sv
// Proximity modulation engine with receiver standby and AHB-Lite registers.
// Assumes one AHB-Lite master, word transfers only, inputs synchronous to clk.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Programmable delay before photodiode evaluation, resets 0
// - Dead time masks part of evaluation, resets 1
// - Standby whenever no measurement is running
// - Only host interface stays active in standby
// - Emitter current sink off during standby
module pms_top
  import pms_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic [31:0]           hrdata,
  output logic                  hresp,
  input  wire logic             pd_in,
  output logic                  led_drive,
  output logic                  led_sink_en,
  output logic [LED_W-1:0]      led_current,
  output logic                  meas_active
);

  pms_state_e          state_r;
  pms_state_e          state_nxt;
  logic                ap_write_r;
  logic                rd_pend_r;
  logic [7:0]          ap_addr_r;
  logic [7:0]          mod_r;
  logic [LED_W-1:0]    led_cur_r;
  logic [7:0]          cfg_r;
  logic [RES_W-1:0]    result_r;
  logic                done_r;
  logic [POS_W-1:0]    per_cnt_r;
  logic signed [ACC_W-1:0] acc_r;
  logic signed [ACC_W-1:0] acc_nxt;
  logic [31:0]         hrdata_r;
  logic                hreadyout_r;
  logic                led_drive_r;
  logic                led_sink_en_r;
  logic                meas_active_r;
  logic                addr_phase;
  logic                wr_ctrl;
  logic                wr_led;
  logic                wr_result;
  logic                wr_mod;
  logic                start_req;
  logic                running;
  logic                phase_on;
  logic [POS_W-1:0]    pos;
  logic                half_end;
  logic [POS_W-1:0]    eval_start;
  logic                eval_en;
  logic                finish;
  logic [31:0]         rd_word;

  // Bus decode: upper address bits are not decoded, so the map aliases
  assign addr_phase = hsel && htrans[HTRANS_ACT] && hready;
  assign wr_ctrl    = ap_write_r && (ap_addr_r == ADDR_CTRL);
  assign wr_led     = ap_write_r && (ap_addr_r == ADDR_LED);
  assign wr_result  = ap_write_r && (ap_addr_r == ADDR_RESULT);
  assign wr_mod     = ap_write_r && (ap_addr_r == ADDR_MOD);
  assign start_req  = wr_ctrl && hwdata[CTRL_START];
  assign running    = (state_r == PMS_MEASURE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ap_write_r <= 1'b0;
      rd_pend_r  <= 1'b0;
      ap_addr_r  <= 8'h00;
    end else begin
      ap_write_r <= addr_phase && hwrite;
      rd_pend_r  <= addr_phase && !hwrite;
      if (addr_phase) begin
        ap_addr_r <= haddr[7:0];
      end
    end
  end

  // Reads take one wait state because the read data is registered before it drives hrdata
  always_comb begin
    case (ap_addr_r)
      ADDR_CTRL:   rd_word = {31'h0, running};
      ADDR_LED:    rd_word = {26'h0, led_cur_r};
      ADDR_RESULT: rd_word = {15'h0, done_r, result_r};
      ADDR_MOD:    rd_word = {24'h0, mod_r};
      ADDR_AMB:    rd_word = 32'h0;
      default:     rd_word = 32'h0;
    endcase
  end

  // The bus side keeps answering in either state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout_r <= 1'b1;
      hrdata_r    <= 32'h0;
    end else begin
      hreadyout_r <= !(addr_phase && !hwrite);
      if (rd_pend_r) begin
        hrdata_r <= rd_word;
      end
    end
  end

  // Software registers; writes to the reserved word are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_r     <= MOD_RESET;
      led_cur_r <= LED_RESET;
    end else begin
      if (wr_mod) begin
        mod_r <= hwdata[7:0];
      end
      if (wr_led) begin
        led_cur_r <= hwdata[LED_W-1:0];
      end
    end
  end

  pms_mod_gen u_mod_gen (
    .clk      (clk),
    .rst_n    (rst_n),
    .run      (running),
    .freq_sel (cfg_r[FRQ_HI:FRQ_LO]),
    .phase_on (phase_on),
    .pos      (pos),
    .half_end (half_end)
  );

  // Evaluation window opens after delay plus dead time in each half
  assign eval_start = {4'h0, cfg_r[DLY_HI:DLY_LO]} + {4'h0, cfg_r[DT_HI:DT_LO]};
  assign eval_en    = running && (pos >= eval_start);
  assign finish     = running && half_end && !phase_on && (per_cnt_r == N_PERIODS - 7'h01);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PMS_STANDBY: begin
        if (start_req) begin
          state_nxt = PMS_MEASURE;
        end
      end
      PMS_MEASURE: begin
        if (finish) begin
          state_nxt = PMS_STANDBY;
        end
      end
      default: state_nxt = PMS_STANDBY;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PMS_STANDBY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Settings are latched at start so a mid-run write cannot tear a period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= MOD_RESET;
    end else if (!running && start_req) begin
      cfg_r <= mod_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_r <= '0;
    end else if (!running) begin
      per_cnt_r <= '0;
    end else if (half_end && !phase_on) begin
      per_cnt_r <= per_cnt_r + 7'h01;
    end
  end

  // Ambient light is cancelled by subtracting the emitter-off half
  always_comb begin
    acc_nxt = acc_r;
    if (eval_en && pd_in) begin
      if (phase_on) begin
        acc_nxt = acc_r + 18'sh00001;
      end else begin
        acc_nxt = acc_r - 18'sh00001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= '0;
    end else if (!running) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // Negative totals clamp to zero; the count cannot exceed the width
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= '0;
    end else if (finish) begin
      result_r <= acc_nxt[ACC_W-1] ? 16'h0000 : acc_nxt[RES_W-1:0];
    end
  end

  // A completion in the clearing cycle keeps the flag set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
    end else if (finish) begin
      done_r <= 1'b1;
    end else if (wr_result && hwdata[RES_DONE]) begin
      done_r <= 1'b0;
    end
  end

  // Emitter sink and measurement power follow the state, no command needed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_drive_r   <= 1'b0;
      led_sink_en_r <= 1'b0;
      meas_active_r <= 1'b0;
    end else begin
      led_drive_r   <= running && phase_on;
      led_sink_en_r <= running;
      meas_active_r <= running;
    end
  end

  assign hreadyout   = hreadyout_r;
  assign hrdata      = hrdata_r;
  assign hresp       = 1'b0;
  assign led_drive   = led_drive_r;
  assign led_sink_en = led_sink_en_r;
  assign led_current = led_cur_r;
  assign meas_active = meas_active_r;

  a_delay_reset: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> mod_r[DLY_HI:DLY_LO] == DLY_RESET)
    else $error("delay field not zero after reset");

  a_dead_reset: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> mod_r[DT_HI:DT_LO] == DT_RESET && mod_r == 8'h01)
    else $error("dead time field not one after reset");

  a_eval_mask: assert property (@(posedge clk) disable iff (!rst_n)
    running && pos < eval_start |-> acc_nxt == acc_r)
    else $error("photodiode evaluated inside delay or dead time");

  a_eval_count: assert property (@(posedge clk) disable iff (!rst_n)
    eval_en && pd_in && phase_on |=> acc_r == $past(acc_r) + 18'sh00001 || !running)
    else $error("evaluation window sample lost");

  a_start_measure: assert property (@(posedge clk) disable iff (!rst_n)
    !running && start_req |=> running ##1 meas_active)
    else $error("start did not leave standby");

  a_finish_standby: assert property (@(posedge clk) disable iff (!rst_n)
    finish |=> !running ##1 (!led_sink_en && !meas_active)[*2])
    else $error("standby not entered after measurement");

  a_sink_standby: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(running) |-> !led_sink_en && !led_drive)
    else $error("emitter sink active in standby");

  a_bus_standby: assert property (@(posedge clk) disable iff (!rst_n)
    rd_pend_r |-> !hreadyout ##1 hreadyout && hrdata == $past(rd_word))
    else $error("register read not answered");

  a_done_wins: assert property (@(posedge clk) disable iff (!rst_n)
    finish && wr_result && hwdata[RES_DONE] |=> done_r)
    else $error("completion lost against clear");

  a_drive_gated: assert property (@(posedge clk) disable iff (!rst_n)
    led_drive |-> led_sink_en)
    else $error("emitter pulsed with sink disabled");

  a_run_outputs: assert property (@(posedge clk) disable iff (!rst_n)
    running |=> led_sink_en && meas_active)
    else $error("measurement outputs not raised while running");

  c_measure_done: cover property (@(posedge clk) disable iff (!rst_n) finish);
  c_read_in_run: cover property (@(posedge clk) disable iff (!rst_n) running && rd_pend_r);
  c_freq_alt: cover property (@(posedge clk) disable iff (!rst_n) running && cfg_r[FRQ_HI:FRQ_LO] == 2'h3);
  c_clear_done: cover property (@(posedge clk) disable iff (!rst_n) done_r ##1 !done_r);

endmodule // pms_top
`default_nettype wire

// >>> include/pms_pkg.sv
// Constants, register map and types for the proximity modulation block.
// Assumes a single 10 MHz clock and an AHB-Lite register bus.
package pms_pkg;

  // Register byte addresses (only the low eight address bits are decoded)
  localparam logic [7:0]  ADDR_CTRL    = 8'h80;
  localparam logic [7:0]  ADDR_LED     = 8'h84;
  localparam logic [7:0]  ADDR_RESULT  = 8'h88;
  localparam logic [7:0]  ADDR_MOD     = 8'h8c;
  localparam logic [7:0]  ADDR_AMB     = 8'h90;

  // Reset values
  localparam logic [7:0]  MOD_RESET    = 8'h01;
  localparam logic [5:0]  LED_RESET    = 6'h02;
  localparam logic [2:0]  DLY_RESET    = 3'h0;
  localparam logic [2:0]  DT_RESET     = 3'h1;

  // Modulation timing field layout
  localparam int          DLY_HI       = 7;
  localparam int          DLY_LO       = 5;
  localparam int          FRQ_HI       = 4;
  localparam int          FRQ_LO       = 3;
  localparam int          DT_HI        = 2;
  localparam int          DT_LO        = 0;

  // Control and result bit positions
  localparam int          CTRL_START   = 0;
  localparam int          RES_DONE     = 16;
  localparam int          HTRANS_ACT   = 1;

  // Widths
  localparam int          LED_W        = 6;
  localparam int          RES_W        = 16;
  localparam int          ACC_W        = 18;
  localparam int          POS_W        = 7;

  // Measurement length in modulation periods
  localparam logic [6:0]  N_PERIODS    = 7'h40;

  // Half-period length in clock cycles for each test frequency
  localparam logic [6:0]  HALF_F0      = 7'h20;
  localparam logic [6:0]  HALF_F1      = 7'h28;
  localparam logic [6:0]  HALF_F2      = 7'h30;
  localparam logic [6:0]  HALF_F3      = 7'h40;

  typedef enum logic {PMS_STANDBY, PMS_MEASURE} pms_state_e;

endpackage

// >>> hw/pms_mod_gen.sv
// Square-wave modulation generator: emitter phase and position in half-period.
// Assumes run is held for a whole measurement and freq_sel is stable meanwhile.
`timescale 1ns/1ps
`default_nettype none
module pms_mod_gen
  import pms_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             run,
  input  wire logic [1:0]       freq_sel,
  output logic                  phase_on,
  output logic [POS_W-1:0]      pos,
  output logic                  half_end
);

  logic [POS_W-1:0] half_len;

  always_comb begin
    case (freq_sel)
      2'h0:    half_len = HALF_F0;
      2'h1:    half_len = HALF_F1;
      2'h2:    half_len = HALF_F2;
      2'h3:    half_len = HALF_F3;
      default: half_len = HALF_F0;
    endcase
  end

  assign half_end = run && (pos == half_len - 7'h01);

  // Every measurement starts on the emitter-on half
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos      <= '0;
      phase_on <= 1'b1;
    end else if (!run) begin
      pos      <= '0;
      phase_on <= 1'b1;
    end else if (half_end) begin
      pos      <= '0;
      phase_on <= ~phase_on;
    end else begin
      pos      <= pos + 7'h01;
    end
  end

  a_half_count: assert property (@(posedge clk) disable iff (!rst_n)
    run && !half_end |=> pos == $past(pos) + 7'h01)
    else $error("half-period counter did not advance");

  a_freq0_len: assert property (@(posedge clk) disable iff (!rst_n)
    run && freq_sel == 2'h0 && half_end |-> pos == 7'h1f)
    else $error("default frequency half-period wrong");

endmodule // pms_mod_gen
`default_nettype wire

// >>> verification/pms_reflector.sv
// Far-side optics model: emitter light comes back on the photodiode.
// Assumes led_drive and led_sink_en come straight from the block under test.
`timescale 1ns/1ps
`default_nettype none
module pms_reflector (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic led_drive,
  input  wire logic led_sink_en,
  output logic      pd_in
);
  // No light without an enabled sink, so a sink left off while driving shows up in the result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_in <= 1'b0;
    end else begin
      pd_in <= led_drive & led_sink_en;
    end
  end
endmodule // pms_reflector
`default_nettype wire

// >>> verification/tb_proximity_modulation_standby.sv
// Self-checking bench for pms_top over AHB-Lite with a reflecting photodiode.
// Assumes hready is looped back from hreadyout, a single slave on the bus.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb_proximity_modulation_standby
  import pms_pkg::*;
;
  logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, rdp = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, pd_in, led_drive, led_sink_en, meas_active;
  logic [LED_W-1:0] led_current, lv;
  logic [31:0] q[$];
  logic [31:0] seed = 32'd56429;
  logic [31:0] exp_w;
  int          err_count = 0, comparisons = 0, n, w, per;
  int          half[4] = '{32, 40, 48, 64};

  pms_top dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .pd_in(pd_in), .led_drive(led_drive), .led_sink_en(led_sink_en),
    .led_current(led_current), .meas_active(meas_active));
  pms_reflector optics (.clk(clk), .rst_n(rst_n), .led_drive(led_drive), .led_sink_en(led_sink_en),
    .pd_in(pd_in));

  always #50 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // One single transfer; a checked read leaves its expected word in the queue
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d, input bit chk);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    if (!w && chk) begin
      q.push_back(d);
    end
    rdp <= !w && chk;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdp <= 1'b0;
  endtask

  // Read data is judged at the edge that ends the data phase
  always @(posedge clk) begin
    if (rdp && hreadyout === 1'b1 && q.size() > 0) begin
      exp_w = q.pop_front();
      `CHK(hrdata, exp_w)
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // A full run of four measurements stays well below this span
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    `CHK(meas_active, 1'b0)
    `CHK(led_sink_en, 1'b0)
    `CHK(hresp, 1'b0)
    xfer(0, ADDR_MOD, 32'h01, 1);
    xfer(0, ADDR_LED, 32'h02, 1);
    xfer(0, ADDR_CTRL, 32'h0, 1);
    xfer(1, ADDR_AMB, 32'hff, 0);
    xfer(0, ADDR_AMB, 32'h0, 1);
    n = rnd();
    lv = n[LED_W-1:0];
    xfer(1, ADDR_LED, {26'h0, lv}, 0);
    xfer(0, ADDR_LED, {26'h0, lv}, 1);
    for (int f = 0; f < 4; f++) begin
      n = rnd();
      // Random delay and dead time must read back unchanged beside the frequency
      xfer(1, ADDR_MOD, {24'h0, n[7:5], f[1:0], n[2:0]}, 0);
      xfer(0, ADDR_MOD, {24'h0, n[7:5], f[1:0], n[2:0]}, 1);
      xfer(1, ADDR_MOD, 32'h01, 0);
      // Odd rates run with the random delay and dead time, even ones with the defaults
      w = f[0] ? n[7:5] + n[2:0] : 1;
      xfer(1, ADDR_MOD, {24'h0, f[0] ? n[7:5] : 3'h0, f[1:0], f[0] ? n[2:0] : 3'h1}, 0);
      xfer(1, ADDR_CTRL, 32'h1, 0);
      do @(posedge clk); while (meas_active !== 1'b1);
      n = 0;
      while (meas_active === 1'b1) begin
        n++;
        if (led_sink_en !== 1'b1) begin
          `CHK(led_sink_en, 1'b1)
        end
        @(posedge clk);
      end
      `CHK(n, 128 * half[f])
      `CHK(led_sink_en, 1'b0)
      `CHK(led_drive, 1'b0)
      `CHK(led_current, lv)
      xfer(0, ADDR_CTRL, 32'h0, 1);
      // The echo lags the internal phase by two cycles, so each half opens with two stale samples
      per = (w == 0) ? half[f] - 4 : (w == 1) ? half[f] - 3 : half[f] - w;
      xfer(0, ADDR_RESULT, 32'h1_0000 + N_PERIODS * per, 1);
      `CHK(hrdata[RES_DONE], 1'b1)
      xfer(1, ADDR_RESULT, 32'h1_0000, 0);
      xfer(0, ADDR_RESULT, N_PERIODS * per, 1);
    end
    xfer(1, ADDR_MOD, 32'h01, 0);
    xfer(0, ADDR_MOD, 32'h01, 1);
    tally_and_finish();
  end
endmodule // tb_proximity_modulation_standby
`default_nettype wire
